// ---- logic/oau_unit.sv ----
// oau_unit: resolves indirect operand references into flat word addresses.
// assumes executor, tool port and retained store all run on clk.
// How it works
// - data memory words only, never bits
// - supervisory low words zeroed at power-up
// - upper words kept across power and mode
// - motion save accepted only in edit mode
// - tool writes to retained area are stored, supervisory role only
// - binary indirect index 0000..7FFF
// - BCD indirect index 0000..9999 only
// - sixteen pointer registers, absolute addresses
// - pointer operand accesses the pointed location
// - constant offset added, pointer unchanged
// - offset register contents added to pointer
// - access first, then increment 1 or 2
// - decrement 1 or 2 first, then access
// - word operand uses pointer value as-is
// - bit operand: word digits plus bit digit
// - pointers cleared on mode change, power-up
// - one pointer set shared by all tasks
// - out-of-range target gives error, no access
// - one flat absolute address space
// - only load instructions write pointers directly
// - sixteen signed 16-bit offset registers
// - illegal access sets readable error flag
`timescale 1ns/1ps
module oau_unit
    import oau_pkg::*;
#(
    parameter int CLR_WORDS = SUP_CLR_WORDS   // words zeroed after power-up
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               sys_rst,
    // module role and operating mode
    input  wire logic               motion_module,   // strap: 1 = motion module
    input  wire logic               mode_edit,       // 1 = edit, 0 = execute
    // operand reference request
    input  wire logic               req_valid,
    input  oau_kind_t               req_kind,
    input  wire logic               req_is_bit,
    input  wire logic [3:0]         req_ptr_sel,
    input  wire logic [3:0]         req_ofs_sel,
    input  wire logic [11:0]        req_const,
    input  wire logic               req_step2,
    input  wire logic [DM_AW-1:0]   req_dm_addr,
    output logic                    req_ready,
    // resolved access
    output logic                    acc_valid,
    output logic [31:0]             acc_addr,
    output logic [3:0]              acc_bit,
    output logic                    acc_is_bit,
    output logic                    acc_err,
    // access error flag
    output logic                    illegal_access_flag,
    input  wire logic               flag_clr,
    // load_pointer_address / load_timer_counter_pointer
    input  wire logic               ptr_ld,
    input  wire logic [3:0]         ptr_ld_sel,
    input  wire logic [31:0]        ptr_ld_value,
    // offset register write
    input  wire logic               ofs_wr,
    input  wire logic [3:0]         ofs_wr_sel,
    input  wire logic [15:0]        ofs_wr_value,
    // executor data-memory write
    input  wire logic               dm_wr,
    input  wire logic [DM_AW-1:0]   dm_wr_addr,
    input  wire logic [15:0]        dm_wr_data,
    // programming tool data-memory write
    input  wire logic               tool_wr,
    input  wire logic [DM_AW-1:0]   tool_addr,
    input  wire logic [15:0]        tool_data,
    // retained store
    output logic                    store_valid,
    output logic [DM_AW-1:0]        store_addr,
    output logic [15:0]             store_data,
    // motion module save control
    input  wire logic               save_req,
    output logic                    save_ack,
    output logic                    save_nak
);
    typedef enum logic [1:0] {ST_CLEAR, ST_IDLE, ST_DM_WAIT} oau_state_t;

    oau_state_t             state_r, state_nxt;   // sequencer state
    logic                   role_r;               // captured module role
    logic                   mode_r;               // last seen mode
    logic                   mode_chg;             // mode switched this cycle
    logic [DM_AW-1:0]       clr_cnt_r;            // power-up clear walk
    logic [PTR_W-1:0]       ptr_r [PTR_N];        // shared pointer set
    logic [OFS_W-1:0]       ofs_r [PTR_N];        // shared offset set
    logic                   take;                 // request accepted
    logic                   ptr_kind;             // request uses a pointer
    logic [PTR_W-1:0]       ptr_cur;              // selected pointer
    logic [PTR_W-1:0]       step;                 // 1 or 2
    logic [PTR_W-1:0]       tgt;                  // combined target
    logic                   tgt_bad;              // target out of range
    logic                   wb_en;                // pointer writeback
    logic [PTR_W-1:0]       wb_val;
    logic [15:0]            mem_rdata;            // named word
    logic                   mem_we;
    logic [DM_AW-1:0]       mem_waddr;
    logic [15:0]            mem_wdata;
    oau_kind_t              kind_r;               // held dm kind
    logic [DM_AW-1:0]       dm_idx;               // decoded dm index
    logic                   dm_bad;               // decode error

    assign take     = req_valid && req_ready;
    assign ptr_kind = (req_kind != OAU_DM_BIN) && (req_kind != OAU_DM_BCD);
    assign mode_chg = (mode_edit != mode_r);
    assign ptr_cur  = ptr_r[req_ptr_sel];
    assign step     = req_step2 ? 32'h0000_0002 : 32'h0000_0001;

    // role strap caught while reset is held
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            role_r <= motion_module;
        end
    end

    // mode tracking for change detection
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_r <= mode_edit;
        end else begin
            mode_r <= mode_edit;
        end
    end

    // pointer target and writeback calculation
    always_comb begin
        tgt    = ptr_cur;
        wb_en  = 1'b0;
        wb_val = ptr_cur;
        unique case (req_kind)
            OAU_PTR_CONST: begin
                tgt = ptr_cur + {{20{req_const[11]}}, req_const};
            end
            OAU_PTR_OFS: begin
                tgt = ptr_cur + {{16{ofs_r[req_ofs_sel][15]}}, ofs_r[req_ofs_sel]};
            end
            OAU_PTR_INC: begin
                wb_en  = 1'b1;
                wb_val = ptr_cur + step;
            end
            OAU_PTR_DEC: begin
                wb_en  = 1'b1;
                wb_val = ptr_cur - step;
                tgt    = ptr_cur - step;
            end
            default: begin
                tgt = ptr_cur;
            end
        endcase
    end

    // range check in the flat address space
    always_comb begin
        if (req_is_bit) begin
            // bit operand: word digits are the top 28 bits
            tgt_bad = ({4'h0, tgt[31:4]} >= IO_LIMIT) ||
                      (({4'h0, tgt[31:4]} >= DM_BASE) &&
                       ({4'h0, tgt[31:4]} < IO_LIMIT));
        end else begin
            tgt_bad = (tgt >= IO_LIMIT);
        end
    end

    // pointer registers: clear beats direct load beats auto update
    generate
        for (genvar i = 0; i < PTR_N; i++) begin : g_ptr
            always_ff @(posedge clk) begin
                if (sys_rst || mode_chg) begin
                    ptr_r[i] <= PTR_RST;
                end else if (ptr_ld && ptr_ld_sel == 4'(i)) begin
                    ptr_r[i] <= ptr_ld_value;
                end else if (take && ptr_kind && wb_en && req_ptr_sel == 4'(i)) begin
                    ptr_r[i] <= wb_val;
                end
            end
            always_ff @(posedge clk) begin
                if (sys_rst || mode_chg) begin
                    ofs_r[i] <= OFS_RST;
                end else if (ofs_wr && ofs_wr_sel == 4'(i)) begin
                    ofs_r[i] <= ofs_wr_value;
                end
            end
        end
    endgenerate

    // data-memory index decode from the named word
    always_comb begin
        dm_idx = mem_rdata[14:0];
        dm_bad = mem_rdata[15];
        if (kind_r == OAU_DM_BCD) begin
            dm_bad = (mem_rdata[15:12] > 4'h9) || (mem_rdata[11:8] > 4'h9) ||
                     (mem_rdata[7:4] > 4'h9) || (mem_rdata[3:0] > 4'h9);
            dm_idx = 15'(mem_rdata[15:12]) * 15'h03E8 + 15'(mem_rdata[11:8]) * 15'h0064
                   + 15'(mem_rdata[7:4]) * 15'h000A + 15'(mem_rdata[3:0]);
        end
    end

    // sequencer state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_CLEAR: begin
                if (role_r || clr_cnt_r == DM_AW'(CLR_WORDS - 1)) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (take && !ptr_kind) begin
                    state_nxt = ST_DM_WAIT;
                end
            end
            ST_DM_WAIT: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r   <= ST_CLEAR;
            req_ready <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            req_ready <= (state_nxt == ST_IDLE);
        end
    end

    // power-up clear walk over the low area
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clr_cnt_r <= '0;
        end else if (state_r == ST_CLEAR) begin
            clr_cnt_r <= clr_cnt_r + 1'b1;
        end
    end

    // held kind of a data-memory request
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            kind_r <= OAU_DM_BIN;
        end else if (take) begin
            kind_r <= req_kind;
        end
    end

    // write port: clear walk, then tool, then executor
    always_comb begin
        mem_we    = 1'b0;
        mem_waddr = dm_wr_addr;
        mem_wdata = dm_wr_data;
        if (state_r == ST_CLEAR) begin
            mem_we    = !role_r;
            mem_waddr = clr_cnt_r;
            mem_wdata = 16'h0000;
        end else if (tool_wr) begin
            mem_we    = 1'b1;
            mem_waddr = tool_addr;
            mem_wdata = tool_data;
        end else begin
            mem_we    = dm_wr;
        end
    end

    oau_word_mem u_mem (
        .clk   (clk),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .raddr (req_dm_addr),
        .rdata (mem_rdata)
    );

    // resolved access outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc_valid  <= 1'b0;
            acc_err    <= 1'b0;
            acc_addr   <= '0;
            acc_bit    <= 4'h0;
            acc_is_bit <= 1'b0;
        end else if (take && ptr_kind) begin
            acc_valid  <= !tgt_bad;
            acc_err    <= tgt_bad;
            acc_addr   <= req_is_bit ? {4'h0, tgt[31:4]} : tgt;
            acc_bit    <= req_is_bit ? tgt[3:0] : 4'h0;
            acc_is_bit <= req_is_bit;
        end else if (state_r == ST_DM_WAIT) begin
            acc_valid  <= !dm_bad;
            acc_err    <= dm_bad;
            acc_addr   <= DM_BASE + {17'h00000, dm_idx};
            acc_bit    <= 4'h0;
            acc_is_bit <= 1'b0;
        end else begin
            acc_valid  <= 1'b0;
            acc_err    <= 1'b0;
        end
    end

    // sticky access error flag, a new error beats the clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            illegal_access_flag <= 1'b0;
        end else if ((take && ptr_kind && tgt_bad) || (state_r == ST_DM_WAIT && dm_bad)) begin
            illegal_access_flag <= 1'b1;
        end else if (flag_clr) begin
            illegal_access_flag <= 1'b0;
        end
    end

    // retained store strobe for tool writes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            store_valid <= 1'b0;
            store_addr  <= '0;
            store_data  <= 16'h0000;
        end else begin
            store_valid <= tool_wr && state_r != ST_CLEAR && !role_r
                           && tool_addr >= SUP_RET_FIRST;
            store_addr  <= tool_addr;
            store_data  <= tool_data;
        end
    end

    // motion save control, edit mode only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            save_ack <= 1'b0;
            save_nak <= 1'b0;
        end else begin
            save_ack <= save_req && role_r && mode_edit;
            save_nak <= save_req && !(role_r && mode_edit);
        end
    end

    // checks
    logic any_ptr;  // any pointer nonzero
    always_comb begin
        any_ptr = 1'b0;
        for (int k = 0; k < PTR_N; k++) begin
            any_ptr = any_ptr | (|ptr_r[k]);
        end
    end

    a_ptr_mode_clear: assert property (@(posedge clk) disable iff (sys_rst)
        mode_chg |=> !any_ptr) else $error("pointers not cleared on mode change");
    a_inc_after_use: assert property (@(posedge clk) disable iff (sys_rst)
        (take && req_kind == OAU_PTR_INC && !req_is_bit && !tgt_bad && !mode_chg && !ptr_ld)
        |=> acc_addr == $past(ptr_cur) && ptr_r[$past(req_ptr_sel)] == $past(ptr_cur) + $past(step))
        else $error("increment order wrong");
    a_dec_before_use: assert property (@(posedge clk) disable iff (sys_rst)
        (take && req_kind == OAU_PTR_DEC && !req_is_bit && !tgt_bad && !mode_chg && !ptr_ld)
        |=> acc_addr == ptr_r[$past(req_ptr_sel)] && acc_valid)
        else $error("decrement order wrong");
    a_const_keeps_ptr: assert property (@(posedge clk) disable iff (sys_rst)
        (take && req_kind == OAU_PTR_CONST && !mode_chg && !ptr_ld)
        |=> ptr_r[$past(req_ptr_sel)] == $past(ptr_cur)) else $error("constant offset moved pointer");
    a_err_no_access: assert property (@(posedge clk) disable iff (sys_rst)
        acc_err |-> !acc_valid && illegal_access_flag) else $error("error with access");
    a_dm_no_bit: assert property (@(posedge clk) disable iff (sys_rst)
        (acc_valid && acc_is_bit) |-> (acc_addr < DM_BASE)) else $error("bit in data memory");
    a_save_edit_only: assert property (@(posedge clk) disable iff (sys_rst)
        save_ack |-> $past(mode_edit) && $past(save_req)) else $error("save outside edit");
    a_store_retained: assert property (@(posedge clk) disable iff (sys_rst)
        store_valid |-> store_addr >= SUP_RET_FIRST) else $error("store of volatile word");
    a_bcd_range: assert property (@(posedge clk) disable iff (sys_rst)
        (state_r == ST_DM_WAIT && kind_r == OAU_DM_BCD)
        |=> !acc_valid || acc_addr <= DM_BASE + {17'h00000, BCD_IDX_MAX})
        else $error("BCD target beyond limit");

    c_dm_bcd: cover property (@(posedge clk) state_r == ST_DM_WAIT && kind_r == OAU_DM_BCD);
    c_ptr_dec: cover property (@(posedge clk) take && req_kind == OAU_PTR_DEC);
    c_err_flag: cover property (@(posedge clk) acc_err);
    c_save_ok: cover property (@(posedge clk) save_ack);
endmodule // oau_unit

// ---- logic/oau_pkg.sv ----
// oau_pkg: constants and types for the indirect operand address unit.
// assumes one clock domain shared with the instruction executor.
package oau_pkg;
    // data-memory area geometry
    localparam int          DM_AW          = 15;              // word index width
    localparam int          DM_WORDS       = 32768;           // D00000..D32767
    localparam logic [14:0] BIN_IDX_MAX    = 15'h7FFF;        // binary index top
    localparam logic [14:0] BCD_IDX_MAX    = 15'h270F;        // 9999, BCD top
    localparam logic [14:0] SUP_RET_FIRST  = 15'h4E20;        // D20000
    localparam logic [14:0] MOT_RET_FIRST  = 15'h7530;        // D30000
    localparam logic [14:0] MOT_SAVE_LAST  = 15'h752F;        // D29999
    localparam int          SUP_CLR_WORDS  = 20000;           // D00000..D19999
    // pointer and offset registers
    localparam int          PTR_N          = 16;              // pointers 0..15
    localparam int          PTR_W          = 32;              // 8 hex digits
    localparam int          OFS_W          = 16;              // signed offsets
    localparam int          CONST_W        = 12;              // -2048..2047
    localparam logic [31:0] PTR_RST        = 32'h0000_0000;   // cleared value
    localparam logic [15:0] OFS_RST        = 16'h0000;
    // flat word address map of I/O memory
    localparam logic [31:0] DM_BASE        = 32'h0001_0000;   // word D00000
    localparam logic [31:0] IO_LIMIT       = 32'h0001_8000;   // first invalid word
    // operand reference kinds
    typedef enum logic [2:0] {
        OAU_DM_BIN,     // binary-indirect data-memory word
        OAU_DM_BCD,     // BCD-indirect data-memory word
        OAU_PTR,        // plain pointer indirect
        OAU_PTR_CONST,  // pointer plus signed constant
        OAU_PTR_OFS,    // pointer plus offset register
        OAU_PTR_INC,    // access then increment
        OAU_PTR_DEC     // decrement then access
    } oau_kind_t;
endpackage : oau_pkg

// ---- logic/oau_word_mem.sv ----
// oau_word_mem: data-memory word store, one write and one read port.
// assumes writes and reads come from one clock; contents survive reset.
`timescale 1ns/1ps
module oau_word_mem
    import oau_pkg::*;
(
    // clock
    input  wire logic              clk,
    // write side
    input  wire logic              we,
    input  wire logic [DM_AW-1:0]  waddr,
    input  wire logic [15:0]       wdata,
    // read side, data one cycle later
    input  wire logic [DM_AW-1:0]  raddr,
    output logic      [15:0]       rdata
);
    logic [15:0] mem_r [DM_WORDS];  // word-only storage, no reset

    // write port
    always_ff @(posedge clk) begin
        if (we) begin
            mem_r[waddr] <= wdata;
        end
    end

    // registered read data
    always_ff @(posedge clk) begin
        rdata <= mem_r[raddr];
    end
endmodule // oau_word_mem

// ---- sim/oau_iomem_model.sv ----
// oau_iomem_model: i/o memory side, logs every access the unit performs.
// assumes it samples the unit's resolved-access outputs on clk.
`timescale 1ns/1ps
module oau_iomem_model (
    // clock
    input  wire logic        clk,
    // resolved access
    input  wire logic        acc_valid,
    input  wire logic [31:0] acc_addr,
    // access log
    output logic      [31:0] last_addr,
    output int               n_acc
);
    // one flat word space, no area select; refused targets never reach here
    initial begin
        last_addr = 32'h0;
        n_acc     = 0;
        forever begin
            @(posedge clk);
            if (acc_valid === 1'b1) begin
                last_addr <= acc_addr;
                n_acc     <= n_acc + 1;
            end
        end
    end
endmodule // oau_iomem_model

// ---- sim/indirect_operand_address_unit_tb.sv ----
// indirect_operand_address_unit_tb: directed scenarios for oau_unit.
// assumes a short power-up clear (CLR_WORDS = 8) and one 250 MHz clock.
`timescale 1ns/1ps
module indirect_operand_address_unit_tb;
    import oau_pkg::*;
    // stimulus and observed signals
    logic clk = 0, sys_rst = 1, motion_module = 0, mode_edit = 1, req_valid = 0;
    oau_kind_t req_kind = OAU_PTR;
    logic req_is_bit = 0, req_step2 = 0, req_ready, acc_valid, acc_is_bit, acc_err;
    logic [3:0] req_ptr_sel = 0, req_ofs_sel = 0, acc_bit, ptr_ld_sel = 0, ofs_wr_sel = 0;
    logic [11:0] req_const = 0;
    logic [14:0] req_dm_addr = 0, dm_wr_addr = 0, tool_addr = 0, store_addr;
    logic [31:0] acc_addr, ptr_ld_value = 0, last_addr, r_addr;
    logic [15:0] ofs_wr_value = 0, dm_wr_data = 0, tool_data = 0, store_data;
    logic illegal_access_flag, flag_clr = 0, ptr_ld = 0, ofs_wr = 0, dm_wr = 0, tool_wr = 0;
    logic store_valid, save_req = 0, save_ack, save_nak, r_err, r_isb;
    logic [3:0] r_bit;
    int n_acc, errors = 0, checks = 0, a0;
    // unit under test and i/o memory model
    oau_unit #(.CLR_WORDS(8)) i_oau_unit (.clk(clk), .sys_rst(sys_rst),
        .motion_module(motion_module), .mode_edit(mode_edit), .req_valid(req_valid),
        .req_kind(req_kind), .req_is_bit(req_is_bit), .req_ptr_sel(req_ptr_sel),
        .req_ofs_sel(req_ofs_sel), .req_const(req_const), .req_step2(req_step2),
        .req_dm_addr(req_dm_addr), .req_ready(req_ready), .acc_valid(acc_valid),
        .acc_addr(acc_addr), .acc_bit(acc_bit), .acc_is_bit(acc_is_bit), .acc_err(acc_err),
        .illegal_access_flag(illegal_access_flag), .flag_clr(flag_clr), .ptr_ld(ptr_ld),
        .ptr_ld_sel(ptr_ld_sel), .ptr_ld_value(ptr_ld_value), .ofs_wr(ofs_wr),
        .ofs_wr_sel(ofs_wr_sel), .ofs_wr_value(ofs_wr_value), .dm_wr(dm_wr),
        .dm_wr_addr(dm_wr_addr), .dm_wr_data(dm_wr_data), .tool_wr(tool_wr),
        .tool_addr(tool_addr), .tool_data(tool_data), .store_valid(store_valid),
        .store_addr(store_addr), .store_data(store_data), .save_req(save_req),
        .save_ack(save_ack), .save_nak(save_nak));
    oau_iomem_model i_oau_iomem_model (.clk(clk), .acc_valid(acc_valid),
        .acc_addr(acc_addr), .last_addr(last_addr), .n_acc(n_acc));
    always #2 clk = ~clk;
    // compare and report
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic give_verdict;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // power cycle in a given role, wait for the clear walk to end
    task automatic pwr(input logic role);
        int n;
        n = 0;
        @(posedge clk) sys_rst <= 1;
        motion_module <= role;
        repeat (12) @(posedge clk);
        sys_rst <= 0;
        do begin @(posedge clk); n++; end while (req_ready !== 1'b1 && n < 40);
        chk(32'(n < 40), 1);
    endtask
    // one operand request, answer captured
    task automatic rq(input oau_kind_t k, input logic [3:0] p, input logic [11:0] c,
                      input logic [14:0] d);
        int n;
        n = 0;
        @(posedge clk) req_valid <= 1;
        req_kind <= k;
        req_ptr_sel <= p;
        req_const <= c;
        req_dm_addr <= d;
        do @(posedge clk); while (req_ready !== 1'b1);
        req_valid <= 0;
        do begin @(posedge clk); n++; end while (acc_valid !== 1 && acc_err !== 1 && n < 6);
        chk(32'(n < 6), 1);
        r_addr = acc_addr;
        r_bit = acc_bit;
        r_isb = acc_is_bit;
        r_err = acc_err;
    endtask
    // one-cycle write strobes
    task automatic ld(input logic [3:0] s, input logic [31:0] v);
        @(posedge clk) ptr_ld <= 1;
        ptr_ld_sel <= s;
        ptr_ld_value <= v;
        @(posedge clk) ptr_ld <= 0;
    endtask
    task automatic wr(input logic [14:0] a, input logic [15:0] v);
        @(posedge clk) dm_wr <= 1;
        dm_wr_addr <= a;
        dm_wr_data <= v;
        @(posedge clk) dm_wr <= 0;
    endtask
    task automatic tw(input logic [14:0] a, input logic s);
        @(posedge clk) tool_wr <= 1;
        tool_addr <= a;
        tool_data <= 16'hBEEF;
        @(posedge clk) tool_wr <= 0;
        @(posedge clk) chk(32'(store_valid), 32'(s));
        if (s) chk({1'b0, store_addr, store_data}, {1'b0, a, 16'hBEEF});
    endtask
    // indirect data-memory words, binary and bcd, with out-of-range indices
    task automatic t_dm;
        wr(100, 16'h7FFF); wr(101, 16'h8000); wr(102, 16'h1234); wr(103, 16'h12A4);
        rq(OAU_DM_BIN, 0, 0, 100); chk(r_addr, DM_BASE + 32'h7FFF);
        @(posedge clk) chk(last_addr, DM_BASE + 32'h7FFF);
        rq(OAU_DM_BIN, 0, 0, 101); chk(32'(r_err), 1);
        rq(OAU_DM_BCD, 0, 0, 102); chk(r_addr, DM_BASE + 32'd1234);
        rq(OAU_DM_BCD, 0, 0, 103); chk(32'(r_err), 1);
    endtask
    // pointer variations on one pointer, constant offset at both extremes
    task automatic t_ptr;
        ld(3, 32'h1000);
        @(posedge clk) ofs_wr <= 1;
        ofs_wr_sel <= 2;
        ofs_wr_value <= 16'hFFFF;
        @(posedge clk) ofs_wr <= 0;
        rq(OAU_PTR, 3, 0, 0); chk(r_addr, 32'h1000);
        rq(OAU_PTR_CONST, 3, 12'h800, 0); chk(r_addr, 32'h0800);
        rq(OAU_PTR_CONST, 3, 12'h7FF, 0); chk(r_addr, 32'h17FF);
        req_ofs_sel <= 2;
        rq(OAU_PTR_OFS, 3, 0, 0); chk(r_addr, 32'h0FFF);
        req_step2 <= 1;
        rq(OAU_PTR_INC, 3, 0, 0); chk(r_addr, 32'h1000);
        rq(OAU_PTR, 3, 0, 0); chk(r_addr, 32'h1002);
        req_step2 <= 0;
        rq(OAU_PTR_DEC, 3, 0, 0); chk(r_addr, 32'h1001);
        rq(OAU_PTR, 3, 0, 0); chk(r_addr, 32'h1001);
    endtask
    // bit operands: carry into next word, no bit access to data memory
    task automatic t_bit;
        ld(5, 32'h0000_000D); ld(7, {DM_BASE[27:0], 4'h0});
        req_is_bit <= 1;
        rq(OAU_PTR_CONST, 5, 12'h005, 0); chk(r_addr, 32'h1);
        chk(32'(r_bit), 32'h2);
        chk(32'(r_isb), 1);
        rq(OAU_PTR, 7, 0, 0); chk(32'(r_err), 1);
        req_is_bit <= 0;
    endtask
    // target past i/o memory refused, sticky flag cleared by pulse
    task automatic t_err;
        ld(6, IO_LIMIT);
        a0 = n_acc;
        rq(OAU_PTR, 6, 0, 0); chk(32'(r_err), 1);
        @(posedge clk) chk(n_acc, a0);
        chk(32'(illegal_access_flag), 1);
        flag_clr <= 1;
        @(posedge clk) flag_clr <= 0;
        @(posedge clk) chk(32'(illegal_access_flag), 0);
    endtask
    // mode change clears pointers and offsets, keeps data memory
    task automatic t_mode;
        wr(4, 16'h0033);
        @(posedge clk) mode_edit <= ~mode_edit;
        rq(OAU_PTR_OFS, 3, 0, 0); chk(r_addr, 32'h0);
        rq(OAU_DM_BIN, 0, 0, 4); chk(r_addr, DM_BASE + 32'h33);
    endtask
    // power cycle: low words zeroed, upper words kept; tool store strobe for retained words only
    task automatic t_keep;
        tw(15'd20000, 1); tw(15'd5, 0);
        wr(2, 16'h0055); wr(15'd20000, 16'h00AB);
        pwr(0);
        rq(OAU_PTR, 5, 0, 0); chk(r_addr, 32'h0);
        rq(OAU_DM_BIN, 0, 0, 2); chk(r_addr, DM_BASE);
        rq(OAU_DM_BIN, 0, 0, 15'd20000); chk(r_addr, DM_BASE + 32'hAB);
    endtask
    // motion role save: accepted in edit mode only
    task automatic t_save(input logic ed);
        @(posedge clk) mode_edit <= ed;
        @(posedge clk) save_req <= 1;
        @(posedge clk) save_req <= 0;
        @(posedge clk) chk({save_ack, save_nak}, {ed, ~ed});
    endtask
    // main sequence
    initial begin
        pwr(0);
        t_dm; t_ptr; t_bit; t_err; t_mode; t_keep;
        pwr(1);
        t_save(1); t_save(0);
        give_verdict;
    end
    // watchdog for a hung handshake
    initial begin
        #40000;
        errors++;
        give_verdict;
    end
endmodule // indirect_operand_address_unit_tb
